// file: rtl/sta_access.sv
// Signalling time slot access between a multiplex path and a link terminal.
// Assumes the multiplex bit clock, frame pulse and receive bit arrive from
// pins, and the terminal octet interface runs on clk_sys.
//
// Chosen here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
module sta_access #(
	parameter int ANA_MAX_DIV = sta_pkg::STA_ANA_MAX_DIV
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Multiplex path pins.
	input wire logic mux_bclk,
	input wire logic mux_fsync,
	input wire logic mux_rx_bit,
	output logic mux_tx_bit,
	output logic mux_tx_en,
	// Signalling link terminal.
	input wire logic [7:0] term_tx_octet,
	output logic term_tx_take,
	output logic [7:0] term_rx_octet,
	output logic term_rx_valid
);
	logic [2:0] bclk_s_q, fs_s_q, rx_s_q;
	logic [2:0] ctrl_q;
	logic [7:0] alt_q;
	logic [4:0] avail_q;
	logic [15:0] rate_q;
	logic [7:0] act_slot_q;
	logic [1:0] act_path_q;
	logic act_inv_q;
	logic [10:0] bcnt_q;
	logic [15:0] ana_cnt_q;
	logic [7:0] rx_sh_q, tx_sh_q, rx_oct_q;
	logic tx_bit_q, tx_en_q, take_q, rxv_q;
	logic [7:0] a_addr_q;
	logic a_wr_q;
	logic [31:0] rdata_q;
	logic hrdy_q, hresp_q;

	// Bus decode.
	wire bus_go = hsel && hready && htrans == sta_pkg::STA_HTRANS_NONSEQ &&
		hsize == sta_pkg::STA_HSIZE_WORD;
	wire wr_ctrl = a_wr_q && a_addr_q == sta_pkg::STA_OFF_CTRL;
	wire wr_alt = a_wr_q && a_addr_q == sta_pkg::STA_OFF_ALT;
	wire wr_avail = a_wr_q && a_addr_q == sta_pkg::STA_OFF_AVAIL;
	wire wr_rate = a_wr_q && a_addr_q == sta_pkg::STA_OFF_RATE;
	wire [31:0] stat_w = {21'h0_0000, act_inv_q, act_path_q, act_slot_q};
	wire [31:0] rd_w =
		haddr == sta_pkg::STA_OFF_CTRL ? {29'h0, ctrl_q} :
		haddr == sta_pkg::STA_OFF_ALT ? {24'h00_0000, alt_q} :
		haddr == sta_pkg::STA_OFF_AVAIL ? {27'h000_0000, avail_q} :
		haddr == sta_pkg::STA_OFF_RATE ? {16'h0000, rate_q} :
		haddr == sta_pkg::STA_OFF_STAT ? stat_w : 32'h0000_0000;

	// Slot choice from the programmed configuration.
	wire [1:0] cfg_path = ctrl_q[1:0];
	wire [7:0] pick_2048 = avail_q[0] ? sta_pkg::STA_SLOT_DEF : alt_q;
	wire [7:0] pick_8448 =
		avail_q[1] ? sta_pkg::STA_SLOT_HI0 :
		avail_q[2] ? sta_pkg::STA_SLOT_HI1 :
		avail_q[3] ? sta_pkg::STA_SLOT_HI2 :
		avail_q[4] ? sta_pkg::STA_SLOT_HI3 : alt_q;
	wire [7:0] pick_slot =
		cfg_path == sta_pkg::STA_P8448 ? pick_8448 :
		cfg_path == sta_pkg::STA_P2048 ? pick_2048 : alt_q;
	wire pick_inv = cfg_path == sta_pkg::STA_P1544 &&
		ctrl_q[sta_pkg::STA_CTRL_INV];

	// Analogue divider never exceeds the slowest legal bit period.
	wire [15:0] max_div = 16'(ANA_MAX_DIV);
	wire [15:0] ana_div = (rate_q == 16'h0000 || rate_q > max_div) ?
		max_div : rate_q;
	wire ana = act_path_q == sta_pkg::STA_PANA;
	wire ana_tick = ana_cnt_q >= ana_div - 16'h0001;

	// Bit timing: multiplex clock edge, or divider tick on analogue links.
	wire bclk_rise = bclk_s_q[1] && !bclk_s_q[2];
	wire stb = ana ? ana_tick : bclk_rise;
	wire fs = fs_s_q[2];
	// The frame pulse restarts the bit count, so a count that started in
	// mid-frame after reset or after the analogue path cannot skew slots.
	wire [10:0] cur = ana ? {8'h00, bcnt_q[2:0]} : fs ? 11'h000 : bcnt_q;
	wire [2:0] bidx = cur[2:0];
	wire hit = ana || cur[10:3] == act_slot_q;
	wire last = stb && hit && bidx == sta_pkg::STA_BIT_LAST;
	wire frame_go = ana ? last : (stb && fs);
	wire rxb = rx_s_q[2] ^ act_inv_q;
	wire [7:0] rx_next = {rx_sh_q[6:0], rxb};

	always_ff @(posedge clk_sys) begin
		bclk_s_q <= {bclk_s_q[1:0], mux_bclk};
		fs_s_q <= {fs_s_q[1:0], mux_fsync};
		rx_s_q <= {rx_s_q[1:0], mux_rx_bit};
	end

	// Bus slave: zero wait states, always OKAY.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			a_wr_q <= 1'b0;
			a_addr_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			hrdy_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			hrdy_q <= 1'b1;
			hresp_q <= 1'b0;
			a_wr_q <= bus_go && hwrite;
			a_addr_q <= haddr;
			if (bus_go && !hwrite) begin
				rdata_q <= rd_w;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_q <= 3'h0;
			alt_q <= sta_pkg::STA_ALT_RST;
			avail_q <= sta_pkg::STA_AVAIL_RST;
			rate_q <= 16'h0000;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= hwdata[2:0];
			end
			if (wr_alt) begin
				alt_q <= hwdata[7:0];
			end
			if (wr_avail) begin
				avail_q <= hwdata[4:0];
			end
			if (wr_rate) begin
				rate_q <= hwdata[15:0];
			end
		end
	end

	// Active configuration is only swapped at a frame boundary.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			act_slot_q <= sta_pkg::STA_SLOT_DEF;
			act_path_q <= sta_pkg::STA_P2048;
			act_inv_q <= 1'b0;
		end else if (frame_go) begin
			act_slot_q <= pick_slot;
			act_path_q <= cfg_path;
			act_inv_q <= pick_inv;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n || !ana || ana_tick) begin
			ana_cnt_q <= 16'h0000;
		end else begin
			ana_cnt_q <= ana_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bcnt_q <= 11'h000;
		end else if (stb) begin
			bcnt_q <= cur + 11'h001;
		end
	end

	// Insertion and extraction in the chosen slot, MSB first both ways.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rx_sh_q <= 8'h00;
			tx_sh_q <= 8'h00;
			tx_bit_q <= 1'b0;
			tx_en_q <= 1'b0;
		end else if (stb) begin
			tx_en_q <= hit;
			if (hit) begin
				rx_sh_q <= rx_next;
				tx_bit_q <= tx_sh_q[7] ^ act_inv_q;
				tx_sh_q <= last ? term_tx_octet : {tx_sh_q[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rx_oct_q <= 8'h00;
			rxv_q <= 1'b0;
			take_q <= 1'b0;
		end else begin
			rxv_q <= last;
			take_q <= last;
			if (last) begin
				rx_oct_q <= rx_next;
			end
		end
	end

	assign hrdata = rdata_q;
	assign hreadyout = hrdy_q;
	assign hresp = hresp_q;
	assign mux_tx_bit = tx_bit_q;
	assign mux_tx_en = tx_en_q;
	assign term_tx_take = take_q;
	assign term_rx_octet = rx_oct_q;
	assign term_rx_valid = rxv_q;

	property p_ts16;
		@(posedge clk_sys) disable iff (!reset_n)
		frame_go && cfg_path == sta_pkg::STA_P2048 && avail_q[0] |=>
			act_slot_q == sta_pkg::STA_SLOT_DEF;
	endproperty
	a_ts16: assert property (p_ts16) else $error("slot 16 not chosen");

	property p_ts16_alt;
		@(posedge clk_sys) disable iff (!reset_n)
		frame_go && cfg_path == sta_pkg::STA_P2048 && !avail_q[0] &&
			$stable(alt_q) |=> act_slot_q == alt_q;
	endproperty
	a_ts16_alt: assert property (p_ts16_alt) else $error("no fallback");

	property p_hi_prio;
		@(posedge clk_sys) disable iff (!reset_n)
		frame_go && cfg_path == sta_pkg::STA_P8448 && avail_q[1] |=>
			act_slot_q == sta_pkg::STA_SLOT_HI0;
	endproperty
	a_hi_prio: assert property (p_hi_prio) else $error("slot 67 lost");

	property p_hi_alt;
		@(posedge clk_sys) disable iff (!reset_n)
		frame_go && cfg_path == sta_pkg::STA_P8448 && avail_q[4:1] == 4'h0
			&& $stable(alt_q) |=> act_slot_q == alt_q;
	endproperty
	a_hi_alt: assert property (p_hi_alt) else $error("8448 fallback");

	property p_no_inv;
		@(posedge clk_sys) disable iff (!reset_n)
		act_path_q != sta_pkg::STA_P1544 |-> !act_inv_q;
	endproperty
	a_no_inv: assert property (p_no_inv) else $error("inverted");

	property p_cfg_frame;
		@(posedge clk_sys) disable iff (!reset_n)
		!$stable(act_slot_q) || !$stable(act_path_q) ||
			!$stable(act_inv_q) |-> $past(frame_go);
	endproperty
	a_cfg_frame: assert property (p_cfg_frame) else $error("mid frame");

	property p_octet;
		@(posedge clk_sys) disable iff (!reset_n)
		rxv_q |-> $past(stb && hit && bidx == sta_pkg::STA_BIT_LAST) &&
			rx_oct_q == $past(rx_next);
	endproperty
	a_octet: assert property (p_octet) else $error("octet slip");

	property p_pair;
		@(posedge clk_sys) disable iff (!reset_n)
		rxv_q == take_q;
	endproperty
	a_pair: assert property (p_pair) else $error("directions split");

	property p_rate;
		@(posedge clk_sys) disable iff (!reset_n)
		ana_cnt_q < max_div;
	endproperty
	a_rate: assert property (p_rate) else $error("analogue too slow");

	property p_excl;
		@(posedge clk_sys) disable iff (!reset_n)
		$rose(tx_en_q) |-> $past(stb && hit);
	endproperty
	a_excl: assert property (p_excl) else $error("foreign slot");
endmodule

// file: rtl/sta_pkg.sv
// Constants shared by the signalling time slot access block.
// Assumes one 250 MHz system clock and an AHB-Lite register bus.
// Overview of operation
// - Digital paths carry signalling at 64 kbit/s.
// - 2048 path uses slot 16 by default.
// - Slot 16 busy: use configured free slot.
// - 2048 and 8448 paths apply no inversion.
// - 8448 path picks slots 67 to 70, priority.
// - None free: use configured free slot.
// - 1544 path inverts every bit when enabled.
// - Analogue link runs at least 4.8 kbit/s.
// - Analogue link sends and receives simultaneously.
// - Both directions move together, same rate.
// - Selected slot carries only signalling bits.
package sta_pkg;
	typedef enum logic [1:0] {
		STA_P2048,
		STA_P8448,
		STA_P1544,
		STA_PANA
	} sta_path_t;
	localparam logic [7:0] STA_OFF_CTRL = 8'h00;
	localparam logic [7:0] STA_OFF_ALT = 8'h04;
	localparam logic [7:0] STA_OFF_AVAIL = 8'h08;
	localparam logic [7:0] STA_OFF_RATE = 8'h0C;
	localparam logic [7:0] STA_OFF_STAT = 8'h10;
	localparam int STA_CTRL_INV = 2;
	localparam logic [7:0] STA_SLOT_DEF = 8'h10;
	localparam logic [7:0] STA_SLOT_HI0 = 8'h43;
	localparam logic [7:0] STA_SLOT_HI1 = 8'h44;
	localparam logic [7:0] STA_SLOT_HI2 = 8'h45;
	localparam logic [7:0] STA_SLOT_HI3 = 8'h46;
	localparam logic [2:0] STA_BIT_LAST = 3'h7;
	localparam logic [1:0] STA_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] STA_HSIZE_WORD = 3'h2;
	localparam logic [7:0] STA_ALT_RST = 8'h01;
	localparam logic [4:0] STA_AVAIL_RST = 5'h1F;
	localparam longint STA_CLK_HZ = 250000000;
	localparam longint STA_ANA_MIN_BPS = 4800;
	localparam int STA_ANA_MAX_DIV = int'(STA_CLK_HZ / STA_ANA_MIN_BPS);
endpackage

// file: bench/sta_mux_model.sv
// Multiplex path model: bit clock, frame pulse and received bits.
// Assumes a 4-cycle bit period and a frame of SLOTS octets.
`timescale 1ns/10ps
module sta_mux_model #(
	parameter int SLOTS = 72
) (
	// Clock.
	input wire logic clk_sys,
	// Path pins.
	output logic mux_bclk,
	output logic mux_fsync,
	output logic mux_rx_bit,
	input wire logic mux_tx_bit,
	input wire logic mux_tx_en,
	// Observation.
	output logic [7:0] frame_no,
	output logic [7:0] tx_seen,
	output logic [7:0] en_bits
);
	int bit_q = 0, nb;
	logic [1:0] ph_q = 2'h0;
	logic [7:0] cnt_q = 8'h00, fn, oct;
	initial {mux_bclk, mux_fsync, mux_rx_bit, frame_no, tx_seen, en_bits} = '0;
	// Each octet carries its slot number mixed with the frame count.
	always @(posedge clk_sys) begin
		ph_q <= ph_q + 2'h1;
		if (ph_q == 2'h1) begin
			mux_bclk <= 1'b0;
			// The held bit answers the strobe of the previous bit.
			if (mux_tx_en === 1'b1) begin
				tx_seen <= {tx_seen[6:0], mux_tx_bit};
				cnt_q <= cnt_q + 8'h01;
			end
		end
		if (ph_q == 2'h3) begin
			nb = (bit_q + 1) % (SLOTS * 8);
			fn = frame_no + 8'(nb == 0);
			oct = 8'(nb / 8) ^ fn;
			mux_bclk <= 1'b1;
			mux_fsync <= nb == 0;
			mux_rx_bit <= oct[7 - nb % 8];
			bit_q <= nb;
			frame_no <= fn;
			if (nb == 0) begin
				en_bits <= cnt_q;
				cnt_q <= 8'h00;
			end
		end
	end
endmodule

// file: bench/testbench.sv
// Bench for the signalling slot access block: bus, path and terminal.
// Assumes the path model sta_mux_model and a 250 MHz system clock.
`timescale 1ns/10ps
module testbench;
	localparam int DIV = 40;
	localparam logic [7:0] TXO = 8'hC6;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] hrdata, rd;
	logic hreadyout, hresp, mux_bclk, mux_fsync, mux_rx_bit;
	logic mux_tx_bit, mux_tx_en, term_tx_take, term_rx_valid;
	logic [7:0] term_rx_octet, frame_no, tx_seen, en_bits;
	int errors = 0;
	int checks_done = 0;
	always #2 clk_sys = ~clk_sys;
	sta_access #(.ANA_MAX_DIV(DIV)) sta_access_i (.clk_sys, .reset_n,
		.hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
		.hwdata, .hrdata, .hreadyout, .hresp, .mux_bclk, .mux_fsync,
		.mux_rx_bit, .mux_tx_bit, .mux_tx_en, .term_tx_octet(TXO),
		.term_tx_take, .term_rx_octet, .term_rx_valid);
	sta_mux_model sta_mux_model_i (.clk_sys, .mux_bclk, .mux_fsync,
		.mux_rx_bit, .mux_tx_bit, .mux_tx_en, .frame_no, .tx_seen,
		.en_bits);
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= sta_pkg::STA_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rck(string what, logic [7:0] a, logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, rd, exp);
	endtask
	task automatic pulse();
		do @(negedge clk_sys); while (term_rx_valid !== 1'b1);
		chk("take", term_tx_take, 1'b1);
	endtask
	task automatic link(string n, logic [2:0] c, logic x, logic [7:0] s);
		bus(1'b1, sta_pkg::STA_OFF_CTRL, {29'h0, c});
		@(frame_no);
		pulse();
		chk({n, " rx"}, term_rx_octet, s ^ frame_no ^ {8{x}});
		@(frame_no);
		@(frame_no);
		#1;
		chk({n, " tx"}, tx_seen, TXO ^ {8{x}});
		chk({n, " bits"}, en_bits, 8'h08);
		bus(1'b0, sta_pkg::STA_OFF_STAT, 32'h0);
		chk({n, " stat"}, rd[10:0], {x, c[1:0], s});
		$display("test %s done", n);
	endtask
	task automatic s_reset();
		logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14};
		logic [31:0] ev[5] = '{32'h0, 32'h1, 32'h1F, 32'h10, 32'h0};
		@(negedge clk_sys);
		chk("hreadyout", hreadyout, 1'b1);
		chk("hresp", hresp, 1'b0);
		chk("tx_en", mux_tx_en, 1'b0);
		bus(1'b1, 8'h10, 32'hFFFF_FFFF);
		bus(1'b1, 8'h14, 32'hFFFF_FFFF);
		foreach (ra[i])
			rck("reg", ra[i], ev[i]);
		$display("test reset done");
	endtask
	task automatic s_fall();
		bus(1'b1, sta_pkg::STA_OFF_ALT, 32'h0000_0005);
		@(frame_no);
		bus(1'b1, sta_pkg::STA_OFF_AVAIL, 32'h0000_001E);
		rck("early stat", sta_pkg::STA_OFF_STAT, 32'h0000_0010);
		link("fall", 3'h0, 1'b0, 8'h05);
	endtask
	task automatic s_8448();
		logic [7:0] av[4] = '{8'h1F, 8'h1D, 8'h11, 8'h01};
		logic [7:0] sl[4] = '{8'h43, 8'h44, 8'h46, 8'h05};
		foreach (av[i]) begin
			bus(1'b1, sta_pkg::STA_OFF_AVAIL, {24'h0, av[i]});
			link("8448", 3'h5, 1'b0, sl[i]);
		end
	endtask
	task automatic s_ana();
		int n;
		logic [31:0] rate[3] = '{32'h0000_000A, 32'h0000_0000,
			32'h0000_FFFF};
		int gap[3] = '{80, DIV * 8, DIV * 8};
		bus(1'b1, sta_pkg::STA_OFF_CTRL, 32'h0000_0003);
		foreach (gap[i]) begin
			bus(1'b1, sta_pkg::STA_OFF_RATE, rate[i]);
			pulse();
			pulse();
			n = 0;
			do begin
				@(negedge clk_sys);
				n++;
			end while (term_rx_valid !== 1'b1);
			chk("ana gap", n, gap[i]);
		end
		$display("test ana done");
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		s_reset();
		link("2048", 3'h4, 1'b0, 8'h10);
		s_fall();
		s_8448();
		bus(1'b1, sta_pkg::STA_OFF_ALT, 32'h0000_0010);
		link("1544", 3'h6, 1'b1, 8'h10);
		s_ana();
		close_out();
	end
	initial begin
		#380_000;
		errors++;
		close_out();
	end
endmodule
